// ---- rag_core.sv ----
`timescale 1ns/10ps
module rag_core (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire rag_pkg::rag_rom_op_t rom_op_i,
  input wire logic [13:0] rom_imm_i,
  input wire rag_pkg::rag_ram_mode_t ram_mode_i,
  input wire rag_pkg::rag_ptr_t ptr_i,
  input wire logic [9:0] direct_addr_i,
  input wire logic [3:0] memreg_sel_i,
  input wire logic [3:0] acc_i,
  input wire logic [3:0] second_accum_i,
  input wire logic [9:0] rom_data_i,
  output logic [13:0] pc_o,
  output logic [13:0] rom_addr_o,
  output logic [9:0] ram_addr_o,
  output logic ram_valid_o,
  output logic [3:0] acc_o,
  output logic [3:0] second_accum_o,
  output logic acc_load_o,
  output logic [3:0] port_out_one_o,
  output logic [3:0] port_out_two_o,
  output logic busy_o
);
  rag_pkg::rag_state_t state;
  rag_pkg::rag_state_t next_state;
  logic [13:0] pc;
  logic [13:0] next_pc;
  logic [9:0] ram_addr_c;
  logic ram_valid_c;

  // Phase of a table read; every branch is refused until it is back in run
  wire in_run = (state == rag_pkg::RAG_ST_RUN);
  wire in_fetch = (state == rag_pkg::RAG_ST_TBL_FETCH);
  wire in_write = (state == rag_pkg::RAG_ST_TBL_WRITE);

  wire take_long = in_run && (rom_op_i == rag_pkg::RAG_OP_LONG_JUMP);
  wire take_page = in_run && (rom_op_i == rag_pkg::RAG_OP_IN_PAGE_JUMP);
  wire take_zero = in_run && (rom_op_i == rag_pkg::RAG_OP_ZERO_PAGE_SUB);
  wire take_tjump = in_run && (rom_op_i == rag_pkg::RAG_OP_TABLE_JUMP);
  wire start_tbl = in_run && (rom_op_i == rag_pkg::RAG_OP_TABLE_READ);

  // pc holds the word now executing, so pc_inc is the already stepped counter
  // whose page bits an in-page jump keeps, even from the last word of a page
  wire [13:0] pc_inc = pc + 14'h0001;
  wire [13:0] long_target = rom_imm_i;
  wire [13:0] in_page = {pc_inc[13:rag_pkg::PAGE_LSB], rom_imm_i[7:0]};
  wire [13:0] zero_page = {8'h00, rom_imm_i[rag_pkg::ZPAGE_W-1:0]};
  wire [13:0] table_addr = {2'b00, rom_imm_i[3:0], second_accum_i, acc_i};

  always_comb begin
    next_pc = pc;
    if (take_long) begin
      next_pc = long_target;
    end else if (take_page) begin
      next_pc = in_page;
    end else if (take_zero) begin
      next_pc = zero_page;
    end else if (take_tjump) begin
      next_pc = table_addr;
    end else if (in_run) begin
      // A table read steps on like any other word; fetch and write hold the counter
      next_pc = pc_inc;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      rag_pkg::RAG_ST_RUN: begin
        if (start_tbl) begin
          next_state = rag_pkg::RAG_ST_TBL_FETCH;
        end
      end
      rag_pkg::RAG_ST_TBL_FETCH: begin
        next_state = rag_pkg::RAG_ST_TBL_WRITE;
      end
      rag_pkg::RAG_ST_TBL_WRITE: begin
        next_state = rag_pkg::RAG_ST_RUN;
      end
      default: begin
        next_state = rag_pkg::RAG_ST_RUN;
      end
    endcase
  end

  // The table address stays on the ROM port through the fetch cycle, so a ROM
  // with a registered output still delivers the table word in the write cycle
  wire [13:0] held_rom = in_fetch ? rom_addr_o : next_pc;
  wire [13:0] next_rom_addr = start_tbl ? table_addr : held_rom;
  wire next_busy = (next_state != rag_pkg::RAG_ST_RUN);

  wire hit_acc = rom_data_i[rag_pkg::TBL_ACC_BIT];
  wire hit_port = rom_data_i[rag_pkg::TBL_PORT_BIT];
  // The two tests are independent, so both destinations may update in one step
  wire write_acc = in_write && hit_acc;
  wire write_port = in_write && hit_port;
  // Low nibble to the first register of each pair, high nibble to the second
  wire rag_pkg::rag_pair_t tdata = rom_data_i[7:0];

  rag_ram_addr rag_ram_addr_i (
    .mode_i(ram_mode_i),
    .ptr_i(ptr_i),
    .direct_addr_i(direct_addr_i),
    .memreg_sel_i(memreg_sel_i),
    .addr_o(ram_addr_c),
    .valid_o(ram_valid_c)
  );

  // Fetch and write cannot be cut short; only a reset leaves them early
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= rag_pkg::RAG_ST_RUN;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // Frozen with the clock enable low, like every other register here
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc <= rag_pkg::PC_RESET;
    end else if (ce_i) begin
      pc <= next_pc;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_addr_o <= rag_pkg::PC_RESET;
    end else if (ce_i) begin
      rom_addr_o <= next_rom_addr;
    end
  end

  // Registered so the RAM array sees a steady address for a whole cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_addr_o <= rag_pkg::RAM_ADDR_RESET;
    end else if (ce_i) begin
      ram_addr_o <= ram_addr_c;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ram_valid_o <= 1'b0;
    end else if (ce_i) begin
      ram_valid_o <= ram_valid_c;
    end
  end

  // Tells the fetch unit to hold its next instruction back
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= next_busy;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_o <= rag_pkg::NIB_RESET;
    end else if (ce_i && write_acc) begin
      acc_o <= tdata.lo;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      second_accum_o <= rag_pkg::NIB_RESET;
    end else if (ce_i && write_acc) begin
      second_accum_o <= tdata.hi;
    end
  end

  // One-cycle strobe for the core's accumulator write-back
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_load_o <= 1'b0;
    end else if (ce_i) begin
      acc_load_o <= write_acc;
    end
  end

  // Port registers keep their value until a table read with bit 9 set
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_out_one_o <= rag_pkg::NIB_RESET;
    end else if (ce_i && write_port) begin
      port_out_one_o <= tdata.lo;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_out_two_o <= rag_pkg::NIB_RESET;
    end else if (ce_i && write_port) begin
      port_out_two_o <= tdata.hi;
    end
  end

  assign pc_o = pc;
endmodule : rag_core

// ---- rag_pkg.sv ----
package rag_pkg;
  localparam int RAM_AW = 10;
  localparam int PC_W = 14;
  localparam int ROM_DW = 10;
  localparam logic [9:0] MEMREG_BASE = 10'h040;
  localparam logic [9:0] MEMREG_LAST = 10'h04f;
  localparam int PAGE_LSB = 8;
  localparam int ZPAGE_W = 6;
  localparam int TBL_ACC_BIT = 8;
  localparam int TBL_PORT_BIT = 9;
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [9:0] RAM_ADDR_RESET = 10'h000;

  typedef enum logic [3:0] {
    RAG_RAM_NONE = 4'h1,
    RAG_RAM_INDIRECT = 4'h2,
    RAG_RAM_DIRECT = 4'h4,
    RAG_RAM_MEMREG = 4'h8
  } rag_ram_mode_t;

  typedef enum logic [2:0] {
    RAG_OP_NONE = 3'h0,
    RAG_OP_LONG_JUMP = 3'h1,
    RAG_OP_IN_PAGE_JUMP = 3'h2,
    RAG_OP_ZERO_PAGE_SUB = 3'h3,
    RAG_OP_TABLE_JUMP = 3'h4,
    RAG_OP_TABLE_READ = 3'h5
  } rag_rom_op_t;

  typedef enum logic [2:0] {
    RAG_ST_RUN = 3'h1,
    RAG_ST_TBL_FETCH = 3'h2,
    RAG_ST_TBL_WRITE = 3'h4
  } rag_state_t;

  typedef struct packed {
    logic [3:0] page;
    logic [3:0] column;
    logic [1:0] index;
  } rag_ptr_t;

  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } rag_pair_t;
endpackage : rag_pkg

// ---- rag_ram_addr.sv ----
`timescale 1ns/10ps
module rag_ram_addr (
  input wire rag_pkg::rag_ram_mode_t mode_i,
  input wire rag_pkg::rag_ptr_t ptr_i,
  input wire logic [9:0] direct_addr_i,
  input wire logic [3:0] memreg_sel_i,
  output logic [9:0] addr_o,
  output logic valid_o
);
  wire [9:0] indirect_addr = {ptr_i.index, ptr_i.column, ptr_i.page};
  wire [9:0] memreg_addr = rag_pkg::MEMREG_BASE | {6'h00, memreg_sel_i};

  always_comb begin
    case (mode_i)
      rag_pkg::RAG_RAM_INDIRECT: addr_o = indirect_addr;
      rag_pkg::RAG_RAM_DIRECT: addr_o = direct_addr_i;
      rag_pkg::RAG_RAM_MEMREG: addr_o = memreg_addr;
      default: addr_o = 10'h000;
    endcase
    valid_o = (mode_i != rag_pkg::RAG_RAM_NONE);
  end
endmodule : rag_ram_addr

// ---- rag_core_assertions.sv ----
`timescale 1ns/10ps
module rag_core_assertions (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic busy_o,
  input wire logic acc_load_o,
  input wire logic ram_valid_o,
  input wire rag_pkg::rag_rom_op_t rom_op_i,
  input wire rag_pkg::rag_ram_mode_t ram_mode_i,
  input wire rag_pkg::rag_ptr_t ptr_i,
  input wire logic [13:0] rom_imm_i,
  input wire logic [13:0] pc_o,
  input wire logic [13:0] rom_addr_o,
  input wire logic [9:0] rom_data_i,
  input wire logic [9:0] ram_addr_o,
  input wire logic [9:0] direct_addr_i,
  input wire logic [3:0] memreg_sel_i,
  input wire logic [3:0] acc_i,
  input wire logic [3:0] second_accum_i,
  input wire logic [3:0] acc_o,
  input wire logic [3:0] second_accum_o,
  input wire logic [3:0] port_out_one_o,
  input wire logic [3:0] port_out_two_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic go = ce_i && !busy_o;
  wire logic tr = go && rom_op_i == rag_pkg::RAG_OP_TABLE_READ;
  wire logic [13:0] pc_inc = pc_o + 14'h1;
  wire logic [13:0] tbl = {2'h0, rom_imm_i[3:0], second_accum_i, acc_i};
  wire logic [9:0] ind = {ptr_i.index, ptr_i.column, ptr_i.page};
  a_long_jump: assert property (go && rom_op_i == rag_pkg::RAG_OP_LONG_JUMP
    |=> pc_o == $past(rom_imm_i)) else $error("long");
  a_page_jump: assert property (go && rom_op_i == rag_pkg::RAG_OP_IN_PAGE_JUMP
    |=> pc_o == {$past(pc_inc[13:8]), $past(rom_imm_i[7:0])}) else $error("page");
  a_zero_page: assert property (go && rom_op_i == rag_pkg::RAG_OP_ZERO_PAGE_SUB
    |=> pc_o == {8'h0, $past(rom_imm_i[5:0])}) else $error("zero");
  a_table_read: assert property (tr
    |=> busy_o && rom_addr_o == $past(tbl) && pc_o == $past(pc_inc)) else $error("read");
  a_acc_load: assert property (tr |-> ##3 acc_load_o == $past(rom_data_i[8]))
    else $error("load");
  a_acc_data: assert property (acc_load_o
    |-> {second_accum_o, acc_o} == $past(rom_data_i[7:0])) else $error("acc");
  a_port_write: assert property (tr |-> ##3 ($past(rom_data_i[9]) ?
    {port_out_two_o, port_out_one_o} == $past(rom_data_i[7:0]) :
    $stable({port_out_two_o, port_out_one_o}))) else $error("port");
  a_ram_ind: assert property (ce_i && ram_mode_i == rag_pkg::RAG_RAM_INDIRECT
    |=> ram_addr_o == $past(ind)) else $error("indirect");
  a_table_jump: assert property (go && rom_op_i == rag_pkg::RAG_OP_TABLE_JUMP
    |=> pc_o == $past(tbl)) else $error("table jump");
  a_ram_direct: assert property (ce_i && ram_mode_i == rag_pkg::RAG_RAM_DIRECT
    |=> ram_valid_o && ram_addr_o == $past(direct_addr_i)) else $error("direct");
  a_ram_memreg: assert property (ce_i && ram_mode_i == rag_pkg::RAG_RAM_MEMREG
    |=> ram_addr_o == rag_pkg::MEMREG_BASE + {6'h00, $past(memreg_sel_i)})
    else $error("memreg");
endmodule : rag_core_assertions
bind rag_core rag_core_assertions rag_core_assertions_i (.*);

// ---- rag_rom_model.sv ----
`timescale 1ns/10ps
module rag_rom_model (
  input wire logic [13:0] addr_i,
  output logic [9:0] data_o
);
  // Control bits follow the low address so each entry picks its own targets
  assign data_o = {addr_i[1:0], ~addr_i[7:0]};
endmodule : rag_rom_model

// ---- test_ram_rom_address_generation.sv ----
`timescale 1ns/10ps
module test_ram_rom_address_generation;
  logic mclk_i = 0, rst_n_i = 0, ce_i = 1, ram_valid_o, acc_load_o, busy_o;
  rag_pkg::rag_rom_op_t rom_op_i = rag_pkg::RAG_OP_NONE;
  rag_pkg::rag_ram_mode_t ram_mode_i = rag_pkg::RAG_RAM_NONE;
  rag_pkg::rag_ptr_t ptr_i = '0;
  logic [13:0] rom_imm_i = '0, pc_o, rom_addr_o;
  logic [9:0] direct_addr_i = '0, rom_data_i, ram_addr_o;
  logic [3:0] memreg_sel_i = '0, acc_i = '0, second_accum_i = 4'h5, acc_o, second_accum_o;
  logic [3:0] port_out_one_o, port_out_two_o, ea, ep;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  rag_core rag_core_i (.*);
  rag_rom_model rag_rom_model_i (.addr_i(rom_addr_o), .data_o(rom_data_i));
  initial forever #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (++cyc == 2000) begin
    n_mismatch++;
    complete_run();
  end
  task complete_run;
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task chk(string s, logic [13:0] e, logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task go(rag_pkg::rag_rom_op_t o, logic [13:0] i);
    rom_op_i = o;
    rom_imm_i = i;
    @(posedge mclk_i) #1;
  endtask : go
  task t_jumps;
    go(rag_pkg::RAG_OP_LONG_JUMP, 14'h12ff);
    chk("pc", 14'h12ff, pc_o);
    go(rag_pkg::RAG_OP_IN_PAGE_JUMP, 14'h0042);
    chk("pc", 14'h1342, pc_o);
    go(rag_pkg::RAG_OP_IN_PAGE_JUMP, 14'h0011);
    chk("pc", 14'h1311, pc_o);
    go(rag_pkg::RAG_OP_ZERO_PAGE_SUB, 14'h3fff);
    chk("pc", 14'h003f, pc_o);
    acc_i = 4'h7;
    go(rag_pkg::RAG_OP_TABLE_JUMP, 14'h3ffc);
    chk("pc", 14'h0c57, pc_o);
    // With the clock enable low a jump must leave the counter alone
    ce_i = 0;
    go(rag_pkg::RAG_OP_LONG_JUMP, 14'h0123);
    chk("pc frozen", 14'h0c57, pc_o);
    ce_i = 1;
  endtask : t_jumps
  task t_table;
    // Both bits first, so the high nibbles hold 4'ha from then on
    for (int k = 3; k >= 0; k--) begin
      acc_i = 4'(k);
      go(rag_pkg::RAG_OP_TABLE_READ, 14'h000a);
      chk("rom_addr", {10'h0a5, acc_i}, rom_addr_o);
      chk("busy", 1'b1, busy_o);
      repeat (2) @(posedge mclk_i) #1;
      if (k[0]) ea = ~acc_i;
      if (k[1]) ep = ~acc_i;
      chk("acc pair", {4'ha, ea}, {second_accum_o, acc_o});
      chk("ports", {4'ha, ep}, {port_out_two_o, port_out_one_o});
      chk("acc_load", k[0], acc_load_o);
      chk("pc", 14'h0c5b - 14'(k), pc_o);
    end
  endtask : t_table
  task t_ram;
    ram_mode_i = rag_pkg::RAG_RAM_INDIRECT;
    ptr_i = '{4'h3, 4'h9, 2'h2};
    go(rag_pkg::RAG_OP_NONE, 14'h0);
    chk("ram_addr", 10'h293, ram_addr_o);
    ram_mode_i = rag_pkg::RAG_RAM_DIRECT;
    direct_addr_i = 10'h2a5;
    go(rag_pkg::RAG_OP_NONE, 14'h0);
    chk("ram_addr", 10'h2a5, ram_addr_o);
    chk("ram_valid", 1'b1, ram_valid_o);
    ram_mode_i = rag_pkg::RAG_RAM_MEMREG;
    memreg_sel_i = 4'hf;
    go(rag_pkg::RAG_OP_NONE, 14'h0);
    chk("ram_addr", 10'h04f, ram_addr_o);
  endtask : t_ram
  initial begin
    repeat (5) @(posedge mclk_i);
    #1 rst_n_i = 1;
    t_jumps();
    t_table();
    t_ram();
    complete_run();
  end
endmodule : test_ram_rom_address_generation
